// ===== cbas_addr_map.sv
`timescale 1ns/1ps
module cbas_addr_map (
	input wire logic              clk,
	input wire logic              reset,
	input wire cbas_pkg::cbas_mode_t mode,
	input wire logic [7:0]        operand,
	input wire logic [7:0]        pointer_value,
	input wire logic [1:0]        bank,
	output logic [7:0]            mapped_addr,
	output logic                  mapped_sfr,
	output logic [2:0]            mapped_bit
);
	import cbas_pkg::*;

	always_ff @(posedge clk) begin
		if (reset) begin
			mapped_addr <= 8'h00;
			mapped_sfr <= 1'b0;
			mapped_bit <= 3'h0;
		end else begin
			mapped_bit <= 3'h0;
			unique case (mode)
				MODE_BANK_REG: begin
					mapped_addr <= {3'b000, bank, operand[2:0]};
					mapped_sfr <= 1'b0;
				end
				MODE_INDIRECT: begin
					// Indirect above the low half lands in upper RAM, never SFRs
					mapped_addr <= pointer_value;
					mapped_sfr <= 1'b0;
				end
				MODE_DIRECT: begin
					mapped_addr <= operand;
					mapped_sfr <= operand >= SFR_BASE;
				end
				MODE_BIT: begin
					mapped_bit <= operand[2:0];
					if (operand < SFR_BASE) begin
						mapped_addr <= BIT_BYTE_BASE + {4'h0, operand[6:3]};
						mapped_sfr <= 1'b0;
					end else begin
						mapped_addr <= {operand[7:3], 3'b000};
						mapped_sfr <= 1'b1;
					end
				end
			endcase
		end
	end

	bank_reg_a: assert property (@(posedge clk) disable iff (reset)
		mode == MODE_BANK_REG |=> mapped_addr == {3'b000, $past(bank), $past(operand[2:0])})
		else $error("bank register address wrong");
	bit_byte_a: assert property (@(posedge clk) disable iff (reset)
		mode == MODE_BIT && operand < SFR_BASE
		|=> mapped_addr == 8'h20 + $past(operand) / 8 && !mapped_sfr)
		else $error("bit address byte wrong");
endmodule // cbas_addr_map

// ===== cbas_core.sv
`timescale 1ns/1ps
// Behaviour
// - long call/jump: 16-bit target, 3 bytes, 4 clocks
// - absolute forms replace low 11 bits of next
// - relative target is next address plus signed byte
// - accumulator zero jumps take 2 or 3
// - compare jumps 3/4, indirect form 4/5
// - decrement jump: register 2/3, direct 3/4
// - indirect jump: accumulator plus pointer, 3 clocks
// - opcode A5 behaves as one-clock no-op
// - register operands in bank, pointers R0/R1 only
// - low 32 bytes are four selectable banks
// - direct below 80 is RAM, above special
// - indirect above 7F reaches upper RAM
// - bit address below 80 maps to bytes 20 to 2F
// - memory space chosen by instruction type
// - flash spans 0000 through 807F
// - store enable bit turns data moves into flash writes
// - extra RAM 2048 bytes via data moves
// - push writes pointer plus one, then increments
// - reset loads stack pointer with 07
// - record shifts in one or two bits
// - record shifts out one or two bits
// - record overflow and underflow reported to debug
module cbas_core (
	input wire logic                 clk,
	input wire logic                 reset,
	input wire logic [7:0]           sfr_addr,
	input wire logic                 sfr_wr,
	input wire logic                 sfr_rd,
	input wire logic [7:0]           sfr_wdata,
	output logic [7:0]               sfr_rdata,
	input wire logic                 instr_valid,
	input wire logic [7:0]           opcode,
	input wire logic [7:0]           operand1,
	input wire logic [7:0]           operand2,
	input wire logic [15:0]          next_pc,
	input wire logic [7:0]           acc,
	input wire logic [15:0]          data_pointer,
	input wire logic [7:0]           operand_value,
	output logic                     dec_valid,
	output logic [1:0]               instr_length,
	output logic [2:0]               instr_cycles,
	output logic                     branch_taken,
	output logic [15:0]              branch_target,
	output logic [7:0]               dec_result,
	input wire cbas_pkg::cbas_mode_t addr_mode,
	input wire logic [7:0]           addr_operand,
	input wire logic [7:0]           pointer_value,
	output logic [7:0]               mapped_addr,
	output logic                     mapped_sfr,
	output logic [2:0]               mapped_bit,
	input wire logic                 push_req,
	input wire logic [7:0]           push_data,
	input wire logic                 pop_req,
	input wire logic                 sp_inc,
	input wire logic                 sp_dec,
	input wire logic                 irq_entry,
	input wire logic [15:0]          irq_pc,
	output logic                     stack_busy,
	output logic                     ram_rd,
	output logic                     ram_wr,
	output logic [7:0]               ram_addr,
	output logic [7:0]               ram_wdata,
	input wire logic [7:0]           ram_rdata,
	output logic [7:0]               pop_data,
	output logic                     pop_done,
	output logic                     ret_done,
	output logic [15:0]              ret_target,
	output logic                     record_overflow,
	output logic                     record_underflow,
	input wire logic [15:0]          code_addr,
	output logic                     code_in_flash,
	input wire logic                 xmove_wr,
	input wire logic [15:0]          xmove_addr,
	input wire logic [7:0]           xmove_data,
	output logic                     flash_wr,
	output logic                     xram_wr,
	output logic [15:0]              store_addr,
	output logic [7:0]               store_data
);
	import cbas_pkg::*;

	cbas_state_t state;
	logic [7:0]  stack_pointer;
	logic [7:0]  program_status_word;
	logic [7:0]  program_store_control;
	logic [7:0]  ret_hold;
	logic [7:0]  sp_up;
	logic [7:0]  sp_down;
	logic [1:0]  bank;
	logic        idle;
	logic        is_call;
	logic        is_ret;
	logic        grant_call;
	logic        grant_ret;
	logic        grant_push;
	logic        grant_pop;
	logic        grant_inc;
	logic        grant_dec;
	logic [15:0] call_pc;
	logic        long_rel;
	logic [7:0]  rel_byte;
	logic [15:0] rel_target;
	logic [7:0]  lhs;
	logic [7:0]  rhs;
	logic [7:0]  dec_value;
	logic [1:0]  next_len;
	logic [2:0]  next_cycles;
	logic        next_taken;
	logic [15:0] next_target;

	cbas_record_if rec ();

	cbas_stack_record u_record (
		.clk   (clk),
		.reset (reset),
		.rec   (rec)
	);

	assign bank = {program_status_word[BANK_HIGH_POS], program_status_word[BANK_LOW_POS]};

	cbas_addr_map u_map (
		.clk           (clk),
		.reset         (reset),
		.mode          (addr_mode),
		.operand       (addr_operand),
		.pointer_value (pointer_value),
		.bank          (bank),
		.mapped_addr   (mapped_addr),
		.mapped_sfr    (mapped_sfr),
		.mapped_bit    (mapped_bit)
	);

	assign sp_up = stack_pointer + 8'h01;
	assign sp_down = stack_pointer - 8'h01;
	assign idle = state == ST_IDLE;
	assign stack_busy = !idle;
	assign is_call = opcode == OP_LONG_CALL || opcode[4:0] == OP_ABSOLUTE_CALL_LOW5;
	assign is_ret = opcode == OP_RET || opcode == OP_INTERRUPT_RETURN;
	assign call_pc = irq_entry ? irq_pc : next_pc;

	// One stack action per idle cycle; anything else waits for the caller
	always_comb begin
		grant_call = 1'b0;
		grant_ret = 1'b0;
		grant_push = 1'b0;
		grant_pop = 1'b0;
		grant_inc = 1'b0;
		grant_dec = 1'b0;
		if (idle) begin
			if (irq_entry || (instr_valid && is_call)) begin
				grant_call = 1'b1;
			end else if (instr_valid && is_ret) begin
				grant_ret = 1'b1;
			end else if (push_req) begin
				grant_push = 1'b1;
			end else if (pop_req) begin
				grant_pop = 1'b1;
			end else if (sp_inc) begin
				grant_inc = 1'b1;
			end else if (sp_dec) begin
				grant_dec = 1'b1;
			end
		end
	end

	assign rec.push_one = grant_push || grant_inc;
	assign rec.push_two = grant_call;
	assign rec.pop_one = grant_pop || grant_dec;
	assign rec.pop_two = grant_ret;
	assign record_overflow = rec.overflow;
	assign record_underflow = rec.underflow;

	always_ff @(posedge clk) begin
		if (reset) begin
			state <= ST_IDLE;
			stack_pointer <= SP_RESET;
			ram_rd <= 1'b0;
			ram_wr <= 1'b0;
			ram_addr <= 8'h00;
			ram_wdata <= 8'h00;
			ret_hold <= 8'h00;
			pop_data <= 8'h00;
			pop_done <= 1'b0;
			ret_done <= 1'b0;
			ret_target <= 16'h0000;
		end else begin
			ram_rd <= 1'b0;
			ram_wr <= 1'b0;
			pop_done <= 1'b0;
			ret_done <= 1'b0;
			unique case (state)
				ST_IDLE: begin
					if (grant_call) begin
						ram_wr <= 1'b1;
						ram_addr <= sp_up;
						ram_wdata <= call_pc[7:0];
						ret_hold <= call_pc[15:8];
						stack_pointer <= sp_up;
						state <= ST_PUSH_HI;
					end else if (grant_ret || grant_pop) begin
						ram_rd <= 1'b1;
						ram_addr <= stack_pointer;
						stack_pointer <= sp_down;
						state <= grant_ret ? ST_RET_ONE : ST_POP_WAIT;
					end else if (grant_push) begin
						ram_wr <= 1'b1;
						ram_addr <= sp_up;
						ram_wdata <= push_data;
						stack_pointer <= sp_up;
					end else if (grant_inc) begin
						stack_pointer <= sp_up;
					end else if (grant_dec) begin
						stack_pointer <= sp_down;
					end else if (sfr_wr && sfr_addr == SP_ADDR) begin
						stack_pointer <= sfr_wdata;
					end
				end
				ST_PUSH_HI: begin
					ram_wr <= 1'b1;
					ram_addr <= sp_up;
					ram_wdata <= ret_hold;
					stack_pointer <= sp_up;
					state <= ST_IDLE;
				end
				ST_POP_WAIT: state <= ST_POP_TAKE;
				ST_POP_TAKE: begin
					pop_data <= ram_rdata;
					pop_done <= 1'b1;
					state <= ST_IDLE;
				end
				ST_RET_ONE: begin
					ram_rd <= 1'b1;
					ram_addr <= stack_pointer;
					stack_pointer <= sp_down;
					state <= ST_RET_TWO;
				end
				ST_RET_TWO: begin
					ret_hold <= ram_rdata;
					state <= ST_RET_THREE;
				end
				ST_RET_THREE: begin
					ret_target <= {ret_hold, ram_rdata};
					ret_done <= 1'b1;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	// Other special register bits stay in their own blocks
	always_ff @(posedge clk) begin
		if (reset) begin
			program_status_word <= PSW_RESET;
			program_store_control <= PROGRAM_STORE_CONTROL_RESET;
			sfr_rdata <= 8'h00;
		end else begin
			if (sfr_wr && sfr_addr == PSW_ADDR) begin
				program_status_word <= sfr_wdata;
			end
			if (sfr_wr && sfr_addr == PROGRAM_STORE_CONTROL_ADDR) begin
				program_store_control <= {7'h00, sfr_wdata[STORE_WE_POS]};
			end
			if (sfr_rd) begin
				unique case (sfr_addr)
					SP_ADDR: sfr_rdata <= stack_pointer;
					PSW_ADDR: sfr_rdata <= program_status_word;
					PROGRAM_STORE_CONTROL_ADDR: sfr_rdata <= program_store_control;
					default: sfr_rdata <= 8'h00;
				endcase
			end
		end
	end

	// Fetches and data moves use separate ports, so no address overlap check
	always_ff @(posedge clk) begin
		if (reset) begin
			code_in_flash <= 1'b0;
			flash_wr <= 1'b0;
			xram_wr <= 1'b0;
			store_addr <= 16'h0000;
			store_data <= 8'h00;
		end else begin
			code_in_flash <= code_addr <= FLASH_LAST;
			flash_wr <= xmove_wr && program_store_control[STORE_WE_POS]
				&& xmove_addr <= FLASH_LAST;
			xram_wr <= xmove_wr && !program_store_control[STORE_WE_POS]
				&& xmove_addr <= XRAM_LAST;
			if (xmove_wr) begin
				store_addr <= xmove_addr;
				store_data <= xmove_data;
			end
		end
	end

	assign long_rel = opcode[7:2] == OP_COMPARE_JUMP_UNEQUAL_A_IMM[7:2] || opcode[7:3] == OP_COMPARE_JUMP_UNEQUAL_REG5
		|| opcode == OP_DECREMENT_JUMP_NONZERO_DIR;
	assign rel_byte = long_rel ? operand2 : operand1;
	assign rel_target = next_pc + {{8{rel_byte[7]}}, rel_byte};
	assign dec_value = operand_value - 8'h01;
	assign lhs = (opcode == OP_COMPARE_JUMP_UNEQUAL_A_IMM || opcode == OP_COMPARE_JUMP_UNEQUAL_A_DIR) ? acc : operand_value;
	assign rhs = opcode == OP_COMPARE_JUMP_UNEQUAL_A_DIR ? operand_value : operand1;

	always_comb begin
		next_len = LEN_ONE;
		next_cycles = CYC_ONE;
		next_taken = 1'b0;
		next_target = next_pc;
		if (opcode == OP_LONG_CALL || opcode == OP_LONG_JUMP) begin
			next_len = LEN_THREE;
			next_cycles = CYC_FOUR;
			next_taken = 1'b1;
			next_target = {operand1, operand2};
		end else if (opcode[4:0] == OP_ABSOLUTE_JUMP_LOW5 || opcode[4:0] == OP_ABSOLUTE_CALL_LOW5) begin
			next_len = LEN_TWO;
			next_cycles = CYC_THREE;
			next_taken = 1'b1;
			next_target = {next_pc[15:11], opcode[7:5], operand1};
		end else if (is_ret) begin
			next_cycles = CYC_FIVE;
		end else if (opcode == OP_SHORT_JUMP) begin
			next_len = LEN_TWO;
			next_cycles = CYC_THREE;
			next_taken = 1'b1;
			next_target = rel_target;
		end else if (opcode == OP_JMP_IND) begin
			next_cycles = CYC_THREE;
			next_taken = 1'b1;
			next_target = data_pointer + {8'h00, acc};
		end else if (opcode == OP_JZ || opcode == OP_JNZ) begin
			next_len = LEN_TWO;
			next_taken = (acc == 8'h00) ^ (opcode == OP_JNZ);
			next_cycles = next_taken ? CYC_THREE : CYC_TWO;
			next_target = rel_target;
		end else if (opcode[7:1] == OP_COMPARE_JUMP_UNEQUAL_IND7) begin
			next_len = LEN_THREE;
			next_taken = lhs != rhs;
			next_cycles = next_taken ? CYC_FIVE : CYC_FOUR;
			next_target = rel_target;
		end else if (opcode[7:2] == OP_COMPARE_JUMP_UNEQUAL_A_IMM[7:2] || opcode[7:3] == OP_COMPARE_JUMP_UNEQUAL_REG5) begin
			next_len = LEN_THREE;
			next_taken = lhs != rhs;
			next_cycles = next_taken ? CYC_FOUR : CYC_THREE;
			next_target = rel_target;
		end else if (opcode[7:3] == OP_DECREMENT_JUMP_NONZERO_REG5) begin
			next_len = LEN_TWO;
			next_taken = dec_value != 8'h00;
			next_cycles = next_taken ? CYC_THREE : CYC_TWO;
			next_target = rel_target;
		end else if (opcode == OP_DECREMENT_JUMP_NONZERO_DIR) begin
			next_len = LEN_THREE;
			next_taken = dec_value != 8'h00;
			next_cycles = next_taken ? CYC_FOUR : CYC_THREE;
			next_target = rel_target;
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			dec_valid <= 1'b0;
			instr_length <= LEN_ONE;
			instr_cycles <= CYC_ONE;
			branch_taken <= 1'b0;
			branch_target <= 16'h0000;
			dec_result <= 8'h00;
		end else begin
			dec_valid <= instr_valid;
			if (instr_valid) begin
				instr_length <= next_len;
				instr_cycles <= next_cycles;
				branch_taken <= next_taken;
				branch_target <= next_target;
				dec_result <= dec_value;
			end
		end
	end

	sp_reset_a: assert property (@(posedge clk) disable iff (reset)
		$fell(reset) |-> stack_pointer == 8'h07)
		else $error("stack pointer reset value wrong");
	push_slot_a: assert property (@(posedge clk) disable iff (reset)
		grant_push |=> ram_wr && ram_addr == $past(sp_up) && stack_pointer == ram_addr)
		else $error("push slot wrong");
	pop_slot_a: assert property (@(posedge clk) disable iff (reset)
		grant_pop |=> ram_rd && ram_addr == $past(stack_pointer) ##2 pop_done)
		else $error("pop order wrong");
	call_bytes_a: assert property (@(posedge clk) disable iff (reset)
		grant_call |=> ram_wdata == $past(call_pc[7:0])
		##1 ram_wr && ram_wdata == $past(call_pc[15:8], 2))
		else $error("call byte order wrong");
	ret_done_a: assert property (@(posedge clk) disable iff (reset)
		grant_ret |-> ##4 ret_done)
		else $error("return not completed in time");
	long_branch_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode == OP_LONG_JUMP
		|=> branch_target == {$past(operand1), $past(operand2)} && instr_cycles == 3'h4
		&& instr_length == 2'h3)
		else $error("long branch decode wrong");
	abs_page_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode[4:0] == OP_ABSOLUTE_JUMP_LOW5
		|=> branch_target[15:11] == $past(next_pc[15:11]) && branch_target[7:0] == $past(operand1))
		else $error("absolute target leaves page");
	short_jump_target_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode == OP_SHORT_JUMP
		|=> branch_target == 16'($past(next_pc) + {{8{$past(operand1[7])}}, $past(operand1)}))
		else $error("relative target wrong");
	acc_jump_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode == OP_JZ && acc != 8'h00 |=> !branch_taken && instr_cycles == 3'h2)
		else $error("zero jump timing wrong");
	compare_jump_unequal_ind_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode[7:1] == OP_COMPARE_JUMP_UNEQUAL_IND7 && operand_value != operand1
		|=> branch_taken && instr_cycles == 3'h5)
		else $error("indirect compare timing wrong");
	decrement_jump_nonzero_one_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode == OP_DECREMENT_JUMP_NONZERO_DIR && operand_value == 8'h01
		|=> !branch_taken && instr_cycles == 3'h3 && dec_result == 8'h00)
		else $error("decrement jump wrong");
	nop_alias_a: assert property (@(posedge clk) disable iff (reset)
		instr_valid && opcode == OP_NOP_ALIAS |=> instr_cycles == 3'h1 && instr_length == 2'h1
		&& !branch_taken)
		else $error("unused opcode not a no-op");
	store_gate_a: assert property (@(posedge clk) disable iff (reset)
		flash_wr |-> program_store_control[0] && !xram_wr)
		else $error("flash written without enable");
endmodule // cbas_core

// ===== cbas_pkg.sv
package cbas_pkg;
	localparam logic [7:0]  SP_ADDR       = 8'h81;
	localparam logic [7:0]  PSW_ADDR      = 8'hD0;
	localparam logic [7:0]  PROGRAM_STORE_CONTROL_ADDR    = 8'h8F;
	localparam logic [7:0]  SP_RESET      = 8'h07;
	localparam logic [7:0]  PSW_RESET     = 8'h00;
	localparam logic [7:0]  PROGRAM_STORE_CONTROL_RESET   = 8'h00;
	localparam int          BANK_LOW_POS  = 3;
	localparam int          BANK_HIGH_POS = 4;
	localparam int          STORE_WE_POS  = 0;
	localparam logic [7:0]  SFR_BASE      = 8'h80;
	localparam logic [7:0]  BIT_BYTE_BASE = 8'h20;
	localparam logic [15:0] FLASH_LAST    = 16'h807F;
	localparam logic [15:0] XRAM_LAST     = 16'h07FF;
	localparam logic [5:0]  RECORD_BITS   = 6'h20;
	localparam logic [7:0]  OP_NOP        = 8'h00;
	localparam logic [7:0]  OP_NOP_ALIAS  = 8'hA5;
	localparam logic [7:0]  OP_LONG_JUMP       = 8'h02;
	localparam logic [7:0]  OP_LONG_CALL      = 8'h12;
	localparam logic [7:0]  OP_RET        = 8'h22;
	localparam logic [7:0]  OP_INTERRUPT_RETURN       = 8'h32;
	localparam logic [7:0]  OP_SHORT_JUMP       = 8'h80;
	localparam logic [7:0]  OP_JMP_IND    = 8'h73;
	localparam logic [7:0]  OP_JZ         = 8'h60;
	localparam logic [7:0]  OP_JNZ        = 8'h70;
	localparam logic [7:0]  OP_COMPARE_JUMP_UNEQUAL_A_IMM = 8'hB4;
	localparam logic [7:0]  OP_COMPARE_JUMP_UNEQUAL_A_DIR = 8'hB5;
	localparam logic [6:0]  OP_COMPARE_JUMP_UNEQUAL_IND7  = 7'h5B;
	localparam logic [4:0]  OP_COMPARE_JUMP_UNEQUAL_REG5  = 5'h17;
	localparam logic [4:0]  OP_DECREMENT_JUMP_NONZERO_REG5  = 5'h1B;
	localparam logic [7:0]  OP_DECREMENT_JUMP_NONZERO_DIR   = 8'hD5;
	localparam logic [4:0]  OP_ABSOLUTE_JUMP_LOW5  = 5'h01;
	localparam logic [4:0]  OP_ABSOLUTE_CALL_LOW5 = 5'h11;
	localparam logic [1:0]  LEN_ONE       = 2'h1;
	localparam logic [1:0]  LEN_TWO       = 2'h2;
	localparam logic [1:0]  LEN_THREE     = 2'h3;
	localparam logic [2:0]  CYC_ONE       = 3'h1;
	localparam logic [2:0]  CYC_TWO       = 3'h2;
	localparam logic [2:0]  CYC_THREE     = 3'h3;
	localparam logic [2:0]  CYC_FOUR      = 3'h4;
	localparam logic [2:0]  CYC_FIVE      = 3'h5;
	typedef enum logic [2:0] {
		ST_IDLE      = 3'b000,
		ST_PUSH_HI   = 3'b001,
		ST_POP_WAIT  = 3'b010,
		ST_POP_TAKE  = 3'b011,
		ST_RET_ONE   = 3'b100,
		ST_RET_TWO   = 3'b101,
		ST_RET_THREE = 3'b110
	} cbas_state_t;
	typedef enum logic [1:0] {
		MODE_BANK_REG = 2'b00,
		MODE_INDIRECT = 2'b01,
		MODE_DIRECT   = 2'b10,
		MODE_BIT      = 2'b11
	} cbas_mode_t;
endpackage

// ===== cbas_ram_model.sv
`timescale 1ns/1ps
module cbas_ram_model (
	input wire logic       clk,
	input wire logic       ram_rd,
	input wire logic       ram_wr,
	input wire logic [7:0] ram_addr,
	input wire logic [7:0] ram_wdata,
	output logic [7:0]     ram_rdata
);
	logic [7:0] mem [256];
	always_ff @(posedge clk) begin
		if (ram_wr) begin
			mem[ram_addr] <= ram_wdata;
		end
	end
	// Churn when idle so stale data never looks valid
	always_ff @(posedge clk) begin
		ram_rdata <= ram_rd ? mem[ram_addr] : ~ram_rdata;
	end
endmodule // cbas_ram_model

// ===== cbas_record_if.sv
`timescale 1ns/1ps
interface cbas_record_if;
	logic       push_one;
	logic       push_two;
	logic       pop_one;
	logic       pop_two;
	logic       overflow;
	logic       underflow;
	logic [5:0] depth;
	modport core (output push_one, push_two, pop_one, pop_two,
		input overflow, underflow, depth);
	modport record (input push_one, push_two, pop_one, pop_two,
		output overflow, underflow, depth);
endinterface

// ===== cbas_stack_record.sv
`timescale 1ns/1ps
module cbas_stack_record (
	input wire logic      clk,
	input wire logic      reset,
	cbas_record_if.record rec
);
	import cbas_pkg::*;
	logic [31:0] bits;
	logic [5:0]  depth;
	logic [5:0]  push_n;
	logic [5:0]  pop_n;
	logic [6:0]  depth_sum;

	assign push_n = rec.push_two ? 6'h02 : (rec.push_one ? 6'h01 : 6'h00);
	assign pop_n = rec.pop_two ? 6'h02 : (rec.pop_one ? 6'h01 : 6'h00);
	assign depth_sum = {1'b0, depth} + {1'b0, push_n};
	assign rec.depth = depth;

	// Call frames record ones, data pushes zeros; oldest bits fall off the top
	always_ff @(posedge clk) begin
		if (reset) begin
			bits <= 32'h00000000;
			depth <= 6'h00;
			rec.overflow <= 1'b0;
			rec.underflow <= 1'b0;
		end else begin
			rec.overflow <= 1'b0;
			rec.underflow <= 1'b0;
			if (rec.push_two) begin
				bits <= {bits[29:0], 2'b11};
			end else if (rec.push_one) begin
				bits <= {bits[30:0], 1'b0};
			end else if (rec.pop_two) begin
				bits <= {2'b00, bits[31:2]};
			end else if (rec.pop_one) begin
				bits <= {1'b0, bits[31:1]};
			end
			if (push_n != 6'h00) begin
				if (depth_sum > {1'b0, RECORD_BITS}) begin
					rec.overflow <= 1'b1;
					depth <= RECORD_BITS;
				end else begin
					depth <= depth_sum[5:0];
				end
			end else if (pop_n != 6'h00) begin
				if (depth < pop_n) begin
					rec.underflow <= 1'b1;
					depth <= 6'h00;
				end else begin
					depth <= depth - pop_n;
				end
			end
		end
	end

	record_full_a: assert property (@(posedge clk) disable iff (reset)
		rec.push_one && !rec.push_two && depth == RECORD_BITS |=> rec.overflow)
		else $error("record overflow not flagged");
	record_empty_a: assert property (@(posedge clk) disable iff (reset)
		rec.pop_two && !rec.push_one && !rec.push_two && depth == 6'h01 |=> rec.underflow)
		else $error("record underflow not flagged");
endmodule // cbas_stack_record

// ===== tb_top.sv
`timescale 1ns/1ps
module tb_top;
	import cbas_pkg::*;
	logic        clk, reset, sfr_wr, sfr_rd, instr_valid, push_req, pop_req, sp_inc, sp_dec;
	logic        irq_entry, xmove_wr, dec_valid, branch_taken, mapped_sfr, stack_busy;
	logic        ram_rd, ram_wr, pop_done, ret_done, record_overflow, record_underflow;
	logic        code_in_flash, flash_wr, xram_wr;
	logic [1:0]  instr_length;
	logic [2:0]  instr_cycles, mapped_bit;
	logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, opcode, operand1, operand2, acc;
	logic [7:0]  operand_value, dec_result, addr_operand, pointer_value, mapped_addr;
	logic [7:0]  push_data, ram_addr, ram_wdata, ram_rdata, pop_data, xmove_data, store_data;
	logic [15:0] next_pc, data_pointer, branch_target, irq_pc, ret_target, code_addr;
	logic [15:0] xmove_addr, store_addr;
	cbas_mode_t  addr_mode;
	int          n_errors, comparisons;
	cbas_core DUT (.*);
	cbas_ram_model ram (.*);
	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("errors %0d comparisons %0d", n_errors, comparisons);
		if (n_errors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic special_register_space(input logic [7:0] a, input logic w, input logic [7:0] d);
		sfr_addr = a;
		sfr_wr = w;
		sfr_rd = !w;
		sfr_wdata = d;
		@(negedge clk);
		sfr_wr = 0;
		sfr_rd = 0;
		@(negedge clk);
	endtask
	task automatic dec(input logic [7:0] op, o1, o2, a, ov, input logic [15:0] pc, d,
		input logic [23:0] exp);
		opcode = op;
		operand1 = o1;
		operand2 = o2;
		acc = a;
		operand_value = ov;
		next_pc = pc;
		data_pointer = d;
		instr_valid = 1;
		@(negedge clk);
		instr_valid = 0;
		chk({dec_valid, instr_length, instr_cycles, branch_taken,
			branch_taken ? branch_target : 16'h0}, {1'b1, exp[21:0]});
		chk(dec_result, 8'(ov - 8'h01));
		@(negedge clk);
	endtask
	task automatic map(input cbas_mode_t m, input logic [7:0] op, p, input logic [11:0] exp);
		addr_mode = m;
		addr_operand = op;
		pointer_value = p;
		@(negedge clk);
		chk({mapped_sfr, mapped_addr, m == MODE_BIT ? mapped_bit : 3'h0}, exp);
	endtask
	task automatic xmv(input logic [15:0] a, input logic [1:0] exp);
		xmove_addr = a;
		xmove_data = 8'h6C;
		xmove_wr = 1;
		@(negedge clk);
		xmove_wr = 0;
		chk({flash_wr, xram_wr}, exp);
		chk({store_addr, store_data}, {a, 8'h6C});
		@(negedge clk);
	endtask
	initial begin
		// Generous bound; the sequence needs about one hundred fifty cycles
		repeat (2000) @(posedge clk);
		n_errors++;
		tally_and_finish;
	end
	initial begin
		{sfr_addr, sfr_wr, sfr_rd, sfr_wdata, instr_valid, opcode, operand1, operand2} = '0;
		{next_pc, acc, data_pointer, operand_value, addr_operand, pointer_value} = '0;
		{push_req, push_data, pop_req, sp_inc, sp_dec, irq_entry, irq_pc, code_addr} = '0;
		{xmove_wr, xmove_addr, xmove_data} = '0;
		addr_mode = MODE_BANK_REG;
		reset = 1;
		repeat (8) @(posedge clk);
		@(negedge clk);
		reset = 0;
		special_register_space(SP_ADDR, 0, 0);
		chk(sfr_rdata, 8'h07);
		dec(OP_LONG_JUMP, 8'h12, 8'h34, 0, 0, 16'h0100, 0, {2'h3, 3'h4, 1'h1, 16'h1234});
		dec(8'hA1, 8'h5A, 0, 0, 0, 16'h3802, 0, {2'h2, 3'h3, 1'h1, 16'h3D5A});
		dec(OP_SHORT_JUMP, 8'hFE, 0, 0, 0, 16'h1000, 0, {2'h2, 3'h3, 1'h1, 16'h0FFE});
		dec(OP_JZ, 8'h10, 0, 0, 0, 16'h2000, 0, {2'h2, 3'h3, 1'h1, 16'h2010});
		dec(OP_JNZ, 8'h10, 0, 0, 0, 16'h2000, 0, {2'h2, 3'h2, 1'h0, 16'h0});
		dec(OP_JZ, 8'h10, 0, 8'h01, 0, 16'h2000, 0, {2'h2, 3'h2, 1'h0, 16'h0});
		dec(8'hB7, 8'h05, 8'h80, 0, 8'h05, 16'h0300, 0, {2'h3, 3'h4, 1'h0, 16'h0});
		dec(8'hB6, 8'h05, 8'h80, 0, 8'h06, 16'h0300, 0, {2'h3, 3'h5, 1'h1, 16'h0280});
		dec(OP_COMPARE_JUMP_UNEQUAL_A_IMM, 8'h07, 8'h02, 8'h05, 0, 16'h0300, 0, {2'h3, 3'h4, 1'h1, 16'h0302});
		dec(8'hDB, 8'h10, 0, 0, 8'h01, 16'h0400, 0, {2'h2, 3'h2, 1'h0, 16'h0});
		dec(OP_DECREMENT_JUMP_NONZERO_DIR, 8'h30, 8'h7F, 0, 8'h02, 16'h0400, 0, {2'h3, 3'h4, 1'h1, 16'h047F});
		dec(OP_DECREMENT_JUMP_NONZERO_DIR, 8'h30, 8'h7F, 0, 8'h01, 16'h0400, 0, {2'h3, 3'h3, 1'h0, 16'h0});
		dec(OP_JMP_IND, 0, 0, 8'h10, 0, 16'h0500, 16'h2000, {2'h1, 3'h3, 1'h1, 16'h2010});
		dec(OP_NOP_ALIAS, 0, 0, 0, 0, 16'h0500, 0, {2'h1, 3'h1, 1'h0, 16'h0});
		special_register_space(PSW_ADDR, 1, 8'h18);
		map(MODE_BANK_REG, 8'h05, 0, {1'h0, 8'h1D, 3'h0});
		map(MODE_INDIRECT, 8'h01, 8'h90, {1'h0, 8'h90, 3'h0});
		map(MODE_DIRECT, 8'h90, 0, {1'h1, 8'h90, 3'h0});
		map(MODE_DIRECT, 8'h45, 0, {1'h0, 8'h45, 3'h0});
		map(MODE_BIT, 8'h13, 0, {1'h0, 8'h22, 3'h3});
		push_data = 8'hAB;
		push_req = 1;
		@(negedge clk);
		push_req = 0;
		@(negedge clk);
		special_register_space(SP_ADDR, 0, 0);
		chk({sfr_rdata, ram.mem[8]}, 16'h08AB);
		irq_pc = 16'h1234;
		irq_entry = 1;
		@(negedge clk);
		irq_entry = 0;
		repeat (3) @(negedge clk);
		special_register_space(SP_ADDR, 0, 0);
		chk({sfr_rdata, ram.mem[9], ram.mem[10]}, 24'h0A3412);
		dec(OP_RET, 0, 0, 0, 0, 0, 0, {2'h1, 3'h5, 1'h0, 16'h0});
		repeat (2) @(negedge clk);
		chk(ret_done, 1'h1);
		special_register_space(SP_ADDR, 0, 0);
		chk({sfr_rdata, ret_target}, 24'h081234);
		pop_req = 1;
		@(negedge clk);
		pop_req = 0;
		chk(stack_busy, 1'h1);
		repeat (2) @(negedge clk);
		chk(pop_done, 1'h1);
		special_register_space(SP_ADDR, 0, 0);
		chk({sfr_rdata, pop_data}, 16'h07AB);
		code_addr = 16'h807F;
		@(negedge clk);
		chk(code_in_flash, 1'h1);
		code_addr = 16'h8080;
		@(negedge clk);
		chk(code_in_flash, 1'h0);
		special_register_space(PROGRAM_STORE_CONTROL_ADDR, 1, 8'h01);
		xmv(16'h0100, 2'h2);
		special_register_space(PROGRAM_STORE_CONTROL_ADDR, 1, 8'h00);
		xmv(16'h0100, 2'h1);
		xmv(16'h0800, 2'h0);
		sp_inc = 1;
		repeat (33) @(negedge clk);
		chk(record_overflow, 1'h1);
		sp_inc = 0;
		sp_dec = 1;
		repeat (33) @(negedge clk);
		chk(record_underflow, 1'h1);
		sp_dec = 0;
		sp_inc = 1;
		@(negedge clk);
		{sp_inc, opcode, instr_valid} = {1'b0, OP_RET, 1'b1};
		@(negedge clk);
		instr_valid = 0;
		chk(record_underflow, 1'h1);
		repeat (4) @(negedge clk);
		tally_and_finish;
	end
endmodule // tb_top
